// file: rtl/dqf_top.sv
// Director queue: prefetch, pre-decode, execution, register file and ALU.
`timescale 1ns/1ps
`include "dqf_consts.svh"
// --------------------------------------------------------------------------
// Overview of operation
// - Queue holds sixteen 32-bit entries, circular.
// - Full/empty set when pointer increment meets other.
// - Full lets only read move; empty only write.
// - Queue controlled by function codes written in.
// - Code 0020 empties queue, zeroes fetch address.
// - Code 0018 starts fetching from fetch address.
// - Code 0022 extracts oldest, or runs next loaded.
// - Fetch address increments per word; two per entry.
// - Entry complete once second word written.
// - Leading code bits of word are pre-decoded.
// - Branch not queued; next word becomes address.
// - Stop not queued; fetch halts, address increments.
// - Terminate queued alone, write pointer advances.
// - Address director: next three words not decoded.
// - Other directors: first, then undecoded second.
// - Next director decoded while previous executes.
// - Data director done early; next data waits.
// - Terminate stops extraction until new 0022.
// - Sixteen-word register file, loadable auto pointers.
// - Register file contents readable by processor.
// - ALU add, sub, dec, pass, complement, write back.
// - Bit compare sets flag on any common bit.
// --------------------------------------------------------------------------
module dqf_top
  import dqf_pkg::*;
#(
  parameter int DEPTH = 16
)
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             mem_req,
  output logic      [15:0] mem_addr,
  input  wire logic        mem_ack,
  input  wire logic [15:0] mem_rdata,
  input  wire logic        xfer_done,
  output logic             cmp_flag
);

  localparam int PW = $clog2(DEPTH);
  localparam int XC = (`DQF_EXEC_NS + `DQF_CLK_NS - 1) / `DQF_CLK_NS;
  // Execution time of one director, at least one cycle.
  localparam logic [3:0] EXEC_CYC = 4'((XC < 1) ? 1 : XC);

  // Pointers are plain wrap counters, so only powers of two work.
  if ((1 << PW) != DEPTH || DEPTH < 2 || DEPTH > 16) begin : g_chk
    $error("DEPTH must be a power of two from 2 to 16");
  end

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  dqf_entry_t      q [DEPTH];         // Director queue storage.
  dqf_entry_t      next_q [DEPTH];
  logic [PW-1:0]   wptr, next_wptr;   // Input pointer.
  logic [PW-1:0]   rptr, next_rptr;   // Output pointer.
  logic            q_full, next_q_full;
  logic            q_empty, next_q_empty;
  dqf_fetch_t      fs, next_fs;       // Loading on or off.
  logic            next_mem_req;
  dqf_word_t       next_mem_addr;
  dqf_word_t       fetch_addr, next_fetch_addr;
  logic            half, next_half;   // Second word of entry due.
  logic            br_pend, next_br_pend;
  logic [1:0]      nodec, next_nodec; // Words still exempt from decode.
  logic            exec_en, next_exec_en;
  logic            out_vld, next_out_vld;
  dqf_entry_t      out_reg, next_out_reg;
  logic [3:0]      exec_cnt, next_exec_cnt;
  logic            data_busy, next_data_busy;
  logic            addr_second, next_addr_second;
  logic            next_cmp_flag;
  dqf_word_t       rf [16];           // Register file.
  dqf_word_t       next_rf [16];
  logic [3:0]      rf_wp, next_rf_wp;
  logic [3:0]      rf_rp, next_rf_rp;
  logic [31:0]     next_prdata;
  logic            next_pready;
  logic            next_pslverr;

  // Per-cycle events, seen by the checks as well.
  logic            setup, acc, func_wr, mclr;
  logic            wr_adv, rd_adv, exec_go, term_hit;
  dqf_word_t       alu_a, alu_b;
  logic [7:0]      op;

  // --------------------------------------------------------------------------
  // Next-state logic
  // --------------------------------------------------------------------------
  // One process computes every next value; the order of the blocks below
  // sets priority, with master clear last so that it overrides them for every register it clears.
  always_comb begin
    next_q           = q;
    next_rf          = rf;
    next_wptr        = wptr;
    next_rptr        = rptr;
    next_q_full      = q_full;
    next_q_empty     = q_empty;
    next_fs          = fs;
    next_mem_req     = mem_req;
    next_mem_addr    = mem_addr;
    next_fetch_addr  = fetch_addr;
    next_half        = half;
    next_br_pend     = br_pend;
    next_nodec       = nodec;
    next_exec_en     = exec_en;
    next_out_vld     = out_vld;
    next_out_reg     = out_reg;
    next_exec_cnt    = exec_cnt;
    next_data_busy   = data_busy;
    next_addr_second = addr_second;
    next_cmp_flag    = cmp_flag;
    next_rf_wp       = rf_wp;
    next_rf_rp       = rf_rp;
    next_prdata      = prdata;
    next_pslverr     = 1'b0;
    wr_adv           = 1'b0;
    rd_adv           = 1'b0;
    exec_go          = 1'b0;
    term_hit         = 1'b0;
    op               = out_reg[31:24];
    alu_a            = rf[out_reg[19:16]];
    alu_b            = out_reg[15:0];
    setup            = psel && !penable;
    acc              = psel && penable && pready;
    func_wr          = acc && pwrite && (paddr == `DQF_OFF_FUNC);
    mclr             = func_wr && (pwdata[15:0] == `DQF_FC_CLEAR);
    // Answer in the cycle after setup; read data is latched in setup, write data taken in access.
    next_pready      = setup;

    // Read mux, latched during setup so that prdata is a flop.
    if (setup) begin
      next_prdata = 32'h0000_0000;
      case (paddr)
        `DQF_OFF_FUNC: next_prdata = 32'h0000_0000;
        `DQF_OFF_STAT: begin
          next_prdata[`DQF_ST_EMPTY]     = q_empty;
          next_prdata[`DQF_ST_FULL]      = q_full;
          next_prdata[`DQF_ST_LOAD]      = (fs == FS_ON);
          next_prdata[`DQF_ST_EXEN]      = exec_en;
          next_prdata[`DQF_ST_OVLD]      = out_vld;
          next_prdata[`DQF_ST_DBUSY]     = data_busy;
          next_prdata[`DQF_ST_CMP]       = cmp_flag;
          next_prdata[`DQF_ST_XBUSY]     = (exec_cnt != 4'h0);
          next_prdata[`DQF_ST_WP +: PW]  = wptr;
          next_prdata[`DQF_ST_RP +: PW]  = rptr;
          next_prdata[`DQF_ST_HALF]      = half;
          next_prdata[`DQF_ST_ASEC]      = addr_second;
        end
        `DQF_OFF_FADDR: next_prdata = {16'h0000, fetch_addr};
        `DQF_OFF_OUTR:  next_prdata = out_reg;
        `DQF_OFF_RFPTR: next_prdata = {24'h00_0000, rf_rp, rf_wp};
        `DQF_OFF_RFDAT: next_prdata = {16'h0000, rf[rf_rp]};
        default:        next_pslverr = 1'b1;
      endcase
    end

    // Function codes from the processor; unknown codes are ignored.
    if (func_wr) begin
      if (pwdata[15:0] == `DQF_FC_LOAD) begin
        next_fs = FS_ON;
      end
      if (pwdata[15:0] == `DQF_FC_EXEC) begin
        next_exec_en = 1'b1;
      end
    end

    // Fetch side: one 16-bit reference at a time.
    if (mem_req && mem_ack) begin
      next_mem_req    = 1'b0;
      next_fetch_addr = fetch_addr + 16'h0001;
      if (br_pend) begin
        // Branch target replaces the address; no increment.
        next_fetch_addr = mem_rdata;
        next_br_pend    = 1'b0;
      end else if (half || nodec != 2'h0) begin
        // Words not looked at by the pre-decode.
        if (nodec != 2'h0) begin
          next_nodec = nodec - 2'h1;
        end
        if (!half) begin
          next_q[wptr][31:16] = mem_rdata;
          next_half           = 1'b1;
        end else begin
          next_q[wptr][15:0] = mem_rdata;
          next_half          = 1'b0;
          wr_adv             = 1'b1;
        end
      end else begin
        // First word of a director: look at its code.
        case (mem_rdata[15:8])
          `DQF_OP_BRANCH: next_br_pend = 1'b1;
          `DQF_OP_STOP:   next_fs = FS_OFF;
          `DQF_OP_TERM: begin
            next_q[wptr] = {mem_rdata, 16'h0000};
            wr_adv       = 1'b1;
          end
          `DQF_OP_ADDR: begin
            next_q[wptr][31:16] = mem_rdata;
            next_half           = 1'b1;
            next_nodec          = `DQF_ADDR_TAIL;
          end
          default: begin
            next_q[wptr][31:16] = mem_rdata;
            next_half           = 1'b1;
          end
        endcase
      end
    end else if (fs == FS_ON && !mem_req && !q_full) begin
      // Nothing is requested while the queue is full.
      next_mem_req  = 1'b1;
      next_mem_addr = fetch_addr;
    end

    // Execution timer and end of a data transfer.
    if (exec_cnt != 4'h0) begin
      next_exec_cnt = exec_cnt - 4'h1;
    end
    if (xfer_done) begin
      next_data_busy = 1'b0;
    end

    // Decode the output register once the previous director is done.
    if (out_vld && exec_cnt == 4'h0) begin
      if (addr_second) begin
        // Second half of an address director is only consumed.
        next_addr_second = 1'b0;
        next_out_vld     = 1'b0;
      end else begin
        case (op)
          `DQF_OP_TERM: begin
            term_hit     = 1'b1;
            next_exec_en = 1'b0;
            next_out_vld = 1'b0;
          end
          `DQF_OP_DATA: begin
            // A second data director waits for the transfer.
            if (!data_busy) begin
              exec_go        = 1'b1;
              next_data_busy = 1'b1;
            end
          end
          `DQF_OP_ADDR: begin
            exec_go          = 1'b1;
            next_addr_second = 1'b1;
          end
          `DQF_OP_ADD: begin
            exec_go                  = 1'b1;
            next_rf[out_reg[19:16]]  = alu_a + alu_b;
          end
          `DQF_OP_SUB: begin
            exec_go                  = 1'b1;
            next_rf[out_reg[19:16]]  = alu_a - alu_b;
          end
          `DQF_OP_DEC: begin
            exec_go                  = 1'b1;
            next_rf[out_reg[19:16]]  = alu_a - 16'h0001;
          end
          `DQF_OP_PASS: begin
            exec_go                  = 1'b1;
            next_rf[out_reg[19:16]]  = alu_a;
          end
          `DQF_OP_COMP: begin
            exec_go                  = 1'b1;
            next_rf[out_reg[19:16]]  = ~alu_a;
          end
          `DQF_OP_BCMP: begin
            exec_go       = 1'b1;
            next_cmp_flag = ((alu_a & alu_b) != 16'h0000);
          end
          default: exec_go = 1'b1;
        endcase
        if (exec_go) begin
          next_out_vld  = 1'b0;
          next_exec_cnt = EXEC_CYC;
        end
      end
    end

    // Refill the output register as soon as it empties, so the next
    // director is decoded while this one still runs.
    if (next_exec_en && !next_out_vld && !q_empty && !mclr) begin
      next_out_reg = q[rptr];
      next_out_vld = 1'b1;
      rd_adv       = 1'b1;
    end

    // Pointers and flags; a step on both sides leaves both flags.
    if (wr_adv) begin
      next_wptr = wptr + 1'b1;
    end
    if (rd_adv) begin
      next_rptr = rptr + 1'b1;
    end
    if (wr_adv && !rd_adv) begin
      next_q_full  = ((wptr + 1'b1) == rptr);
      next_q_empty = 1'b0;
    end
    if (rd_adv && !wr_adv) begin
      next_q_empty = ((rptr + 1'b1) == wptr);
      next_q_full  = 1'b0;
    end

    // Register file pointers and data port; each access steps a pointer.
    if (acc && pwrite && paddr == `DQF_OFF_RFPTR) begin
      next_rf_wp = pwdata[3:0];
      next_rf_rp = pwdata[7:4];
    end
    if (acc && paddr == `DQF_OFF_RFDAT) begin
      if (pwrite) begin
        next_rf[rf_wp] = pwdata[15:0];
        next_rf_wp     = rf_wp + 4'h1;
      end else begin
        next_rf_rp = rf_rp + 4'h1;
      end
    end

    // Master clear drops any reference in flight as well.
    if (mclr) begin
      next_wptr        = '0;
      next_rptr        = '0;
      next_q_empty     = 1'b1;
      next_q_full      = 1'b0;
      next_fetch_addr  = `DQF_FADDR_RST;
      next_fs          = FS_OFF;
      next_mem_req     = 1'b0;
      next_half        = 1'b0;
      next_br_pend     = 1'b0;
      next_nodec       = 2'h0;
      next_exec_en     = 1'b0;
      next_out_vld     = 1'b0;
      next_addr_second = 1'b0;
      next_exec_cnt    = 4'h0;
      next_data_busy   = 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  // All state holds while the clock enable is low.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < DEPTH; i++) begin
        q[i] <= 32'h0000_0000;
      end
      for (int j = 0; j < 16; j++) begin
        rf[j] <= 16'h0000;
      end
      wptr        <= '0;
      rptr        <= '0;
      q_full      <= 1'b0;
      q_empty     <= 1'b1;
      fs          <= FS_OFF;
      mem_req     <= 1'b0;
      mem_addr    <= 16'h0000;
      fetch_addr  <= `DQF_FADDR_RST;
      half        <= 1'b0;
      br_pend     <= 1'b0;
      nodec       <= 2'h0;
      exec_en     <= 1'b0;
      out_vld     <= 1'b0;
      out_reg     <= 32'h0000_0000;
      exec_cnt    <= 4'h0;
      data_busy   <= 1'b0;
      addr_second <= 1'b0;
      cmp_flag    <= 1'b0;
      rf_wp       <= 4'h0;
      rf_rp       <= 4'h0;
      prdata      <= 32'h0000_0000;
      pready      <= 1'b0;
      pslverr     <= 1'b0;
    end else if (ce) begin
      q           <= next_q;
      rf          <= next_rf;
      wptr        <= next_wptr;
      rptr        <= next_rptr;
      q_full      <= next_q_full;
      q_empty     <= next_q_empty;
      fs          <= next_fs;
      mem_req     <= next_mem_req;
      mem_addr    <= next_mem_addr;
      fetch_addr  <= next_fetch_addr;
      half        <= next_half;
      br_pend     <= next_br_pend;
      nodec       <= next_nodec;
      exec_en     <= next_exec_en;
      out_vld     <= next_out_vld;
      out_reg     <= next_out_reg;
      exec_cnt    <= next_exec_cnt;
      data_busy   <= next_data_busy;
      addr_second <= next_addr_second;
      cmp_flag    <= next_cmp_flag;
      rf_wp       <= next_rf_wp;
      rf_rp       <= next_rf_rp;
      prdata      <= next_prdata;
      pready      <= next_pready;
      pslverr     <= next_pslverr;
    end
  end

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  full_set_a: assert property (ce && wr_adv && !rd_adv && !mclr && (wptr + 1'b1) == rptr |=> q_full)
    else $error("queue full flag not raised");
  empty_set_a: assert property (ce && rd_adv && !wr_adv && !mclr && (rptr + 1'b1) == wptr |=> q_empty)
    else $error("queue empty flag not raised");
  full_no_write_a: assert property (q_full |-> !wr_adv)
    else $error("write pointer moved while full");
  empty_no_read_a: assert property (q_empty |-> !rd_adv)
    else $error("read pointer moved while empty");
  clear_zero_a: assert property (ce && mclr |=> q_empty && fetch_addr == 16'h0000 && !mem_req)
    else $error("master clear incomplete");
  fetch_step_a: assert property (ce && mem_req && mem_ack && !br_pend && !mclr
                                 |=> fetch_addr == $past(fetch_addr) + 16'h0001)
    else $error("fetch address did not step");
  branch_load_a: assert property (ce && mem_req && mem_ack && br_pend && !mclr
                                  |=> fetch_addr == $past(mem_rdata))
    else $error("branch target not loaded");
  full_hold_a: assert property (q_full && !mem_req |=> !mem_req)
    else $error("reference issued while full");
  term_stop_a: assert property (ce && term_hit && !func_wr |=> !exec_en && !out_vld)
    else $error("terminate did not stop extraction");
  data_hold_a: assert property (data_busy && out_vld && exec_cnt == 4'h0 && !addr_second
                                && op == `DQF_OP_DATA |-> !exec_go)
    else $error("data director ran during transfer");

  fill_c: cover property (ce && wr_adv && (wptr + 1'b1) == rptr);
  term_c: cover property (ce && term_hit);
  branch_c: cover property (ce && mem_ack && br_pend);
  overlap_c: cover property (ce && rd_adv && exec_cnt != 4'h0);

endmodule

// file: inc/dqf_consts.svh
// Register offsets, field positions, codes and timing of the director queue.
`ifndef DQF_CONSTS_SVH
`define DQF_CONSTS_SVH
`define DQF_OFF_FUNC   8'h00
`define DQF_OFF_STAT   8'h04
`define DQF_OFF_FADDR  8'h08
`define DQF_OFF_OUTR   8'h0c
`define DQF_OFF_RFPTR  8'h10
`define DQF_OFF_RFDAT  8'h14
`define DQF_FC_CLEAR   16'h0020
`define DQF_FC_LOAD    16'h0018
`define DQF_FC_EXEC    16'h0022
`define DQF_OP_BRANCH  8'h01
`define DQF_OP_STOP    8'h02
`define DQF_OP_TERM    8'h03
`define DQF_OP_ADDR    8'h04
`define DQF_OP_DATA    8'h05
`define DQF_OP_ADD     8'h10
`define DQF_OP_SUB     8'h11
`define DQF_OP_DEC     8'h12
`define DQF_OP_PASS    8'h13
`define DQF_OP_COMP    8'h14
`define DQF_OP_BCMP    8'h15
`define DQF_ST_EMPTY   0
`define DQF_ST_FULL    1
`define DQF_ST_LOAD    2
`define DQF_ST_EXEN    3
`define DQF_ST_OVLD    4
`define DQF_ST_DBUSY   5
`define DQF_ST_CMP     6
`define DQF_ST_XBUSY   7
`define DQF_ST_WP      8
`define DQF_ST_RP      12
`define DQF_ST_HALF    16
`define DQF_ST_ASEC    17
`define DQF_ADDR_TAIL  2'h3
`define DQF_FADDR_RST  16'h0000
`define DQF_CLK_NS     40
`define DQF_EXEC_NS    160
`endif

// file: inc/dqf_pkg.sv
// Types shared by the director queue design.
package dqf_pkg;
  typedef logic [15:0] dqf_word_t;
  typedef logic [31:0] dqf_entry_t;
  typedef enum logic [0:0] {FS_OFF, FS_ON} dqf_fetch_t;
endpackage

// file: tb/dqf_mem_model.sv
// Core memory model that answers director references with a random delay.
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// Memory side of the director fetch path
// ----------------------------------------------------------------------
module dqf_mem_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        mem_req,
  input  wire logic [15:0] mem_addr,
  output logic             mem_ack,
  output logic      [15:0] mem_rdata
);
  logic [15:0] mem [0:255];  // Word store, loaded by the bench.
  logic [1:0]  wait_c;       // Cycles still to wait before answering.
  // One answer for each request; data is scrambled outside the answer cycle,
  // so a design that samples it late sees garbage, not a stale word.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_ack   <= 1'b0;
      mem_rdata <= 16'h0000;
      wait_c    <= 2'h0;
    end else begin
      mem_ack   <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mem_req && !mem_ack) begin
        if (wait_c == 2'h0) begin
          mem_ack   <= 1'b1;
          mem_rdata <= mem[mem_addr[7:0]];
          wait_c    <= 2'($urandom % 4);
        end else begin
          wait_c <= wait_c - 2'h1;
        end
      end
    end
  end
endmodule

// file: tb/director_queue_fetch_execute_tb.sv
// Self-checking bench for the director queue.
`timescale 1ns/1ps
`include "dqf_consts.svh"
module director_queue_fetch_execute_tb;
  import dqf_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        mem_req, mem_ack, cmp_flag;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q, st;
  logic [15:0] mem_addr, mem_rdata, a1, a2, e;
  logic [15:0] b [0:5];
  logic [7:0]  ops [0:5];
  logic        err, xfer_done;   // Error of the last transfer; end of a data transfer.
  int          mismatches, n_compared, cycles, i;

  dqf_top dut (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .xfer_done(xfer_done), .cmp_flag(cmp_flag));
  dqf_mem_model mdl (.pclk(pclk), .presetn(presetn), .mem_req(mem_req), .mem_addr(mem_addr),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata));

  always #20 pclk = ~pclk;
  // The whole run needs well under a thousand cycles; the ceiling of 20000 leaves wide margin.
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      complete_run();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One APB transfer; the request stands until pready is seen high.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q   = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic poll(input logic [31:0] m, input logic [31:0] v);
    for (int k = 0; k < 300; k++) begin
      apb(1'b0, `DQF_OFF_STAT, 32'h0);
      if ((q & m) === v) break;
    end
    chk(q & m, v);
  endtask

  function automatic logic [15:0] alu(input logic [7:0] op, input logic [15:0] x, input logic [15:0] y);
    case (op)
      `DQF_OP_ADD:  return x + y;
      `DQF_OP_SUB:  return x - y;
      `DQF_OP_DEC:  return x - 16'h0001;
      `DQF_OP_PASS: return x;
      default: return ~x;
    endcase
  endfunction

  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    void'($urandom(32'h57fb2f8e));
    {pclk, presetn, psel, penable, pwrite, paddr, pwdata, xfer_done} = '0;
    {mismatches, n_compared, cycles} = '0;
    ops = '{8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15};
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `DQF_OFF_STAT, 32'h0);
    chk(q & 32'h3, 32'h1);
    apb(1'b0, 8'h40, 32'h0);
    chk({31'h0, err}, 32'h1);
    // Seed registers 1 and 2 through the auto-incrementing write pointer.
    a1 = 16'($urandom);
    a2 = 16'($urandom);
    apb(1'b1, `DQF_OFF_RFPTR, 32'h1);
    apb(1'b1, `DQF_OFF_RFDAT, {16'h0, a1});
    apb(1'b1, `DQF_OFF_RFDAT, {16'h0, a2});
    // Program: branch to 0x10, six ALU directors, terminate, address director, stop.
    mdl.mem[0] = 16'h0100;
    mdl.mem[1] = 16'h0010;
    for (i = 0; i < 6; i++) begin
      b[i] = 16'($urandom);
      mdl.mem[16 + 2 * i] = {ops[i], 4'h0, (i == 5) ? 4'h2 : 4'h1};
      mdl.mem[17 + 2 * i] = b[i];
    end
    mdl.mem[28] = 16'h0300;
    mdl.mem[29] = 16'h0400;
    // The second entry of the address director starts with a terminate code:
    // it must be neither pre-decoded while loading nor decoded when it reaches the output.
    for (i = 30; i < 33; i++) mdl.mem[i] = (i == 31) ? 16'h0300 : 16'($urandom);
    mdl.mem[33] = 16'h0200;
    // Two data directors and a stop, loaded later while execution is already enabled.
    for (i = 34; i < 38; i++) mdl.mem[i] = (i % 2 == 0) ? {`DQF_OP_DATA, 8'($urandom)} : 16'($urandom);
    mdl.mem[38] = 16'h0200;
    apb(1'b1, `DQF_OFF_FUNC, {16'h0, `DQF_FC_CLEAR});
    apb(1'b0, `DQF_OFF_FADDR, 32'h0);
    chk(q, 32'h0);
    apb(1'b1, `DQF_OFF_FUNC, {16'h0, `DQF_FC_LOAD});
    poll(32'h4, 32'h0);
    apb(1'b0, `DQF_OFF_FADDR, 32'h0);
    chk(q, 32'h22);
    apb(1'b0, `DQF_OFF_STAT, 32'h0);
    chk(((q >> 8) - (q >> 12)) & 32'hf, 32'h9);
    // Run until the terminate director stops extraction.
    apb(1'b1, `DQF_OFF_FUNC, {16'h0, `DQF_FC_EXEC});
    poll(32'hf080, 32'h7000);
    e = a1;
    for (i = 0; i < 5; i++) e = alu(ops[i], e, b[i]);
    chk({31'h0, cmp_flag}, {31'h0, (a2 & b[5]) != 16'h0});
    apb(1'b1, `DQF_OFF_RFPTR, 32'h10);
    apb(1'b0, `DQF_OFF_RFDAT, 32'h0);
    chk(q & 32'hffff, {16'h0, e});
    apb(1'b1, `DQF_OFF_FUNC, {16'h0, `DQF_FC_EXEC});
    poll(32'hf089, 32'h9009);
    // Resume loading after the stop: the queue is empty, so the data directors run at once,
    // and the second one waits until the first transfer reports its end.
    apb(1'b1, `DQF_OFF_FUNC, {16'h0, `DQF_FC_LOAD});
    for (i = 0; i < 2; i++) begin
      poll(32'hffbf, (i == 0) ? 32'hbb39 : 32'hbb29);
      @(posedge pclk) xfer_done <= 1'b1;
      @(posedge pclk) xfer_done <= 1'b0;
    end
    poll(32'h20, 32'h0);
    apb(1'b0, `DQF_OFF_FADDR, 32'h0);
    chk(q, 32'h27);
    // Fill the queue from 0x40 until it refuses further references.
    mdl.mem[1] = 16'h0040;
    for (i = 0; i < 32; i++) mdl.mem[64 + i] = (i % 2 == 0) ? {8'h30, 8'($urandom)} : 16'($urandom);
    apb(1'b1, `DQF_OFF_FUNC, {16'h0, `DQF_FC_CLEAR});
    apb(1'b1, `DQF_OFF_FUNC, {16'h0, `DQF_FC_LOAD});
    poll(32'h2, 32'h2);
    repeat (20) @(posedge pclk);
    apb(1'b0, `DQF_OFF_FADDR, 32'h0);
    chk(q, 32'h60);
    apb(1'b0, `DQF_OFF_STAT, 32'h0);
    chk(((q >> 8) ^ (q >> 12)) & 32'hf, 32'h0);
    apb(1'b1, `DQF_OFF_FUNC, {16'h0, `DQF_FC_CLEAR});
    apb(1'b0, `DQF_OFF_STAT, 32'h0);
    chk(q & 32'h3, 32'h1);
    complete_run();
  end
endmodule
